/* File: pkg/adc_port_pkg.sv */
// Shared constants and types for the converter's serial command port.
// Assumes a host that drives chip select, bit clock and serial data.

package adc_port_pkg;

	// ------------------------------------------------------------------
	// Command bytes
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_GAIN_WR  = 8'h02;
	localparam logic [7:0] CMD_CFG_WR   = 8'h03;
	localparam logic [7:0] CMD_CSR_WR   = 8'h05;
	localparam logic [7:0] CMD_GAIN_RD  = 8'h0A;
	localparam logic [7:0] CMD_CFG_RD   = 8'h0B;
	localparam logic [7:0] CMD_CSR_RD   = 8'h0D;
	localparam logic [7:0] CMD_CONVERT  = 8'h80;
	localparam logic [7:0] CMD_SELF_OFS = 8'h81;

	// ------------------------------------------------------------------
	// Sizes, field positions and reset values
	// ------------------------------------------------------------------
	localparam int WORD_W        = 24;
	localparam int NUM_CSR       = 8;
	localparam int NUM_CH        = 8;
	localparam logic [6:0] SYNC_ONES = 7'h7F;
	localparam logic [4:0] BYTE_LAST = 5'h07;
	localparam logic [4:0] WORD_LAST = 5'h17;
	localparam int DP_LSB        = 12;
	localparam int RC_BIT        = 17;
	localparam int LP_BIT        = 18;
	localparam int MC_BIT        = 19;
	localparam int SU_POL        = 0;
	localparam int SU_RANGE_LSB  = 1;
	localparam int SU_OWR_LSB    = 4;
	localparam int SU_CH_LSB     = 7;
	localparam int SU_LATCH_LSB  = 10;
	localparam logic [23:0] CFG_RESET  = 24'h000000;
	localparam logic [23:0] GAIN_RESET = 24'h000000;
	localparam logic [23:0] CSR_RESET  = 24'h000000;
	localparam logic [23:0] OFS_RESET  = 24'h000000;
	localparam int CONV_CYCLES_DEF = 256;
	localparam int CAL_CYCLES_DEF  = 256;

	// ------------------------------------------------------------------
	// Port states and transfer targets
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_CMD    = 3'b000,
		ST_WR     = 3'b001,
		ST_RD     = 3'b010,
		ST_WAIT   = 3'b011,
		ST_RESULT = 3'b100
	} port_state_t;

	typedef enum logic [2:0] {
		TGT_CFG  = 3'b000,
		TGT_CSR  = 3'b001,
		TGT_GAIN = 3'b010,
		TGT_RES  = 3'b011,
		TGT_CAL  = 3'b100
	} target_t;

endpackage : adc_port_pkg

/* File: verilog/adc_serial_command_port.sv */
// Serial command port of a multi-channel converter, with a small
// conversion and calibration engine on the system clock.
// Assumes sclk is quiet while cs_n is high and analog_sample is
// synchronous to clock.
//
// Summary of operation
// - 127 ones then a zero resynchronises port
// - Reset leaves port in command state
// - Command state waits for a valid command
// - Depth pointer sets setup count minus one
// - 0x0B reads, 0x03 writes configuration
// - 0x05 writes, 0x0D reads setup register burst
// - Setup selects channel, polarity, range, rate, latch
// - 0x81 starts self-offset calibration on setup one
// - Serial out falls when calibration completes
// - Calibration updates the physical channel's register
// - Write is command plus three data bytes
// - Bits shift most significant first
// - 0x0A reads channel one gain register
// - Port works only while chip select low
// - Single conversion needs multi and loop cleared
// - 0x80 converts setup one, serial out falls
// - Result goes out as three bytes
// - 0x02 writes channel one gain register

module adc_serial_command_port #(
	parameter int unsigned CONV_CYCLES = adc_port_pkg::CONV_CYCLES_DEF,
	parameter int unsigned CAL_CYCLES  = adc_port_pkg::CAL_CYCLES_DEF,
	parameter bit          WORD16      = 1'b0
) (
	input  wire logic                            clock,
	input  wire logic                            rstn,
	input  wire logic                            sclk,
	input  wire logic                            cs_n,
	input  wire logic                            serial_in,
	input  wire logic [adc_port_pkg::WORD_W-1:0] analog_sample,
	output logic                                 serial_out,
	output logic [3:0]                           depth_pointer,
	output logic                                 multi_conversion_bit,
	output logic                                 loop_bit,
	output logic                                 read_convert_bit,
	output logic [adc_port_pkg::WORD_W-1:0]      gain_channel_one,
	output logic                                 conv_busy,
	output logic [2:0]                           active_channel,
	output logic                                 active_polarity,
	output logic [2:0]                           active_range,
	output logic [2:0]                           active_owr,
	output logic [1:0]                           latch_outputs
);
	import adc_port_pkg::*;

	localparam logic [15:0] CONV_LOAD = 16'(CONV_CYCLES - 1);
	localparam logic [15:0] CAL_LOAD  = 16'(CAL_CYCLES - 1);

	// ------------------------------------------------------------------
	// Link domain: frame state
	// ------------------------------------------------------------------
	port_state_t       state_r, state_nxt;
	target_t           tgt_r, tgt_nxt;
	logic [4:0]        bit_cnt_r, bit_cnt_nxt;
	logic [2:0]        idx_r, idx_nxt;
	logic [23:0]       shift_in_r;
	logic [23:0]       tx_r, tx_nxt;
	logic [6:0]        ones_r;
	logic              start_now;
	logic [23:0]       cfg_r;
	logic [23:0]       gain1_r;
	logic [23:0]       csr_mem [NUM_CSR];
	logic              start_tgl_r;
	logic              start_cal_r;
	logic              done_tgl_r;
	logic [23:0]       result_r;

	// Chip select high ends the frame at once, since sclk stops with it.
	wire        frame_rst_n = rstn & ~cs_n;
	wire [23:0] rx_next     = {shift_in_r[22:0], serial_in};
	wire [7:0]  cmd_byte    = rx_next[7:0];
	wire        byte_end    = (bit_cnt_r == BYTE_LAST);
	wire        word_end    = (bit_cnt_r == WORD_LAST);
	wire        resync      = !serial_in && (ones_r == SYNC_ONES);
	wire [2:0]  dp_last     = cfg_r[DP_LSB+3:DP_LSB+1];
	wire        last_word   = (idx_r == dp_last);
	wire        single_mode = !cfg_r[MC_BIT] && !cfg_r[LP_BIT];
	wire        wr_commit   = (state_r == ST_WR) && word_end && !resync;
	wire        pending     = start_tgl_r ^ done_tgl_r;

	// Next frame state; the resync pattern overrides the state, the bit count and the start.
	always_comb begin
		state_nxt   = state_r;
		tgt_nxt     = tgt_r;
		idx_nxt     = idx_r;
		bit_cnt_nxt = bit_cnt_r + 5'h01;
		tx_nxt      = {tx_r[22:0], 1'b0};
		start_now   = 1'b0;
		case (state_r)
		ST_CMD: begin
			if (byte_end) begin
				bit_cnt_nxt = 5'h00;
				case (cmd_byte)
				CMD_CFG_RD: begin
					state_nxt = ST_RD;
					tgt_nxt   = TGT_CFG;
					tx_nxt    = cfg_r;
				end
				CMD_CFG_WR: begin
					state_nxt = ST_WR;
					tgt_nxt   = TGT_CFG;
				end
				CMD_CSR_RD: begin
					state_nxt = ST_RD;
					tgt_nxt   = TGT_CSR;
					idx_nxt   = 3'h0;
					tx_nxt    = csr_mem[0];
				end
				CMD_CSR_WR: begin
					state_nxt = ST_WR;
					tgt_nxt   = TGT_CSR;
					idx_nxt   = 3'h0;
				end
				CMD_GAIN_RD: begin
					state_nxt = ST_RD;
					tgt_nxt   = TGT_GAIN;
					tx_nxt    = gain1_r;
				end
				CMD_GAIN_WR: begin
					state_nxt = ST_WR;
					tgt_nxt   = TGT_GAIN;
				end
				CMD_CONVERT: begin
					if (single_mode) begin
						state_nxt = ST_WAIT;
						tgt_nxt   = TGT_RES;
						start_now = 1'b1;
					end
				end
				CMD_SELF_OFS: begin
					state_nxt = ST_WAIT;
					tgt_nxt   = TGT_CAL;
					start_now = 1'b1;
				end
				default: begin
				end
				endcase
			end
		end
		ST_WR: begin
			// Exactly three data bytes form one word.
			if (word_end) begin
				bit_cnt_nxt = 5'h00;
				if (tgt_r == TGT_CSR && !last_word) begin
					idx_nxt = idx_r + 3'h1;
				end else begin
					state_nxt = ST_CMD;
				end
			end
		end
		ST_RD, ST_RESULT: begin
			if (word_end) begin
				bit_cnt_nxt = 5'h00;
				if (state_r == ST_RD && tgt_r == TGT_CSR && !last_word) begin
					idx_nxt = idx_r + 3'h1;
					tx_nxt  = csr_mem[idx_r + 3'h1];
				end else begin
					state_nxt = ST_CMD;
				end
			end
		end
		ST_WAIT: begin
			// After a conversion any eight clocks open the result transfer, after a calibration they return to ST_CMD; serial_in is not checked.
			if (byte_end) begin
				bit_cnt_nxt = 5'h00;
				if (tgt_r == TGT_RES) begin
					state_nxt = ST_RESULT;
					tx_nxt    = result_r;
				end else begin
					state_nxt = ST_CMD;
				end
			end
		end
		default: begin
			state_nxt = ST_CMD;
		end
		endcase
		if (resync) begin
			state_nxt   = ST_CMD;
			bit_cnt_nxt = 5'h00;
			start_now   = 1'b0;
		end
	end

	// Frame registers; every frame starts in the command state.
	always_ff @(posedge sclk or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			state_r    <= ST_CMD;
			tgt_r      <= TGT_CFG;
			bit_cnt_r  <= 5'h00;
			idx_r      <= 3'h0;
			shift_in_r <= 24'h000000;
			tx_r       <= 24'h000000;
			ones_r     <= 7'h00;
		end else begin
			state_r    <= state_nxt;
			tgt_r      <= tgt_nxt;
			bit_cnt_r  <= bit_cnt_nxt;
			idx_r      <= idx_nxt;
			shift_in_r <= rx_next;
			tx_r       <= tx_nxt;
			ones_r     <= serial_in ? (ones_r == SYNC_ONES ? ones_r
				: ones_r + 7'h01) : 7'h00;
		end
	end

	// Register file; survives chip select, cleared only by rstn.
	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			cfg_r       <= CFG_RESET;
			gain1_r     <= GAIN_RESET;
			start_tgl_r <= 1'b0;
			start_cal_r <= 1'b0;
			for (int i = 0; i < NUM_CSR; i++) begin
				csr_mem[i] <= CSR_RESET;
			end
		end else begin
			if (wr_commit && tgt_r == TGT_CFG) begin
				cfg_r <= rx_next;
			end
			if (wr_commit && tgt_r == TGT_GAIN) begin
				gain1_r <= rx_next;
			end
			if (wr_commit && tgt_r == TGT_CSR) begin
				csr_mem[idx_r] <= rx_next;
			end
			if (start_now) begin
				start_tgl_r <= ~start_tgl_r;
				start_cal_r <= (cmd_byte == CMD_SELF_OFS);
			end
		end
	end

	// While waiting, the pin shows the pending job; low means done.
	assign serial_out = (state_r == ST_WAIT) ? pending : tx_r[23];
	assign depth_pointer        = cfg_r[DP_LSB+3:DP_LSB];
	assign multi_conversion_bit = cfg_r[MC_BIT];
	assign loop_bit             = cfg_r[LP_BIT];
	assign read_convert_bit     = cfg_r[RC_BIT];
	assign gain_channel_one     = gain1_r;

	// ------------------------------------------------------------------
	// System clock domain: conversion and calibration engine
	// ------------------------------------------------------------------
	logic        st_s1_r, st_s2_r, seen_r;
	logic        busy_r, cal_r;
	logic [15:0] cnt_r;
	logic [2:0]  chan_r, range_r, owr_r;
	logic        pol_r;
	logic [1:0]  latch_r;
	logic [23:0] ofs_mem [NUM_CH];

	// Setup one is the upper half of the first setup register.  It is
	// static while a job runs, so the start toggle qualifies it.
	wire [11:0] setup1    = csr_mem[0][23:12];
	wire        start_evt = st_s2_r ^ seen_r;
	wire [23:0] diff      = analog_sample - ofs_mem[chan_r];
	wire [23:0] conv_word = WORD16 ? {diff[23:8], 8'h00} : diff;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_s1_r    <= 1'b0;
			st_s2_r    <= 1'b0;
			seen_r     <= 1'b0;
			busy_r     <= 1'b0;
			cal_r      <= 1'b0;
			cnt_r      <= 16'h0000;
			chan_r     <= 3'h0;
			range_r    <= 3'h0;
			owr_r      <= 3'h0;
			pol_r      <= 1'b0;
			latch_r    <= 2'h0;
			done_tgl_r <= 1'b0;
			result_r   <= 24'h000000;
			for (int i = 0; i < NUM_CH; i++) begin
				ofs_mem[i] <= OFS_RESET;
			end
		end else begin
			st_s1_r <= start_tgl_r;
			st_s2_r <= st_s1_r;
			if (start_evt) begin
				seen_r  <= st_s2_r;
				busy_r  <= 1'b1;
				cal_r   <= start_cal_r;
				cnt_r   <= start_cal_r ? CAL_LOAD : CONV_LOAD;
				chan_r  <= setup1[SU_CH_LSB+2:SU_CH_LSB];
				range_r <= setup1[SU_RANGE_LSB+2:SU_RANGE_LSB];
				owr_r   <= setup1[SU_OWR_LSB+2:SU_OWR_LSB];
				pol_r   <= setup1[SU_POL];
				latch_r <= setup1[SU_LATCH_LSB+1:SU_LATCH_LSB];
			end else if (busy_r) begin
				if (cnt_r == 16'h0000) begin
					busy_r     <= 1'b0;
					done_tgl_r <= seen_r;
					if (cal_r) begin
						ofs_mem[chan_r] <= analog_sample;
					end else begin
						result_r <= conv_word;
					end
				end else begin
					cnt_r <= cnt_r - 16'h0001;
				end
			end
		end
	end

	assign conv_busy       = busy_r;
	assign active_channel  = chan_r;
	assign active_polarity = pol_r;
	assign active_range    = range_r;
	assign active_owr      = owr_r;
	assign latch_outputs   = latch_r;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence cmd_seen(logic [7:0] c);
		state_r == ST_CMD && byte_end && !resync && cmd_byte == c;
	endsequence

	resync_entry_a: assert property (
		@(posedge sclk) disable iff (!frame_rst_n)
		resync |=> state_r == ST_CMD && bit_cnt_r == 5'h00)
		else $error("resync did not return to command state");
	cmd_wait_a: assert property (
		@(posedge sclk) disable iff (!frame_rst_n)
		(state_r == ST_CMD && !byte_end) |=> state_r == ST_CMD)
		else $error("left command state mid byte");
	cfg_read_a: assert property (
		@(posedge sclk) disable iff (!frame_rst_n)
		cmd_seen(CMD_CFG_RD) |=> state_r == ST_RD && tx_r == $past(cfg_r))
		else $error("configuration read not loaded");
	cfg_write_a: assert property (
		@(posedge sclk) disable iff (!frame_rst_n)
		(wr_commit && tgt_r == TGT_CFG)
		|=> cfg_r == $past(rx_next) && state_r == ST_CMD)
		else $error("configuration write wrong");
	burst_len_a: assert property (
		@(posedge sclk) disable iff (!frame_rst_n)
		(wr_commit && tgt_r == TGT_CSR)
		|=> (state_r == ST_CMD) == $past(last_word))
		else $error("setup burst length wrong");
	msb_first_a: assert property (
		@(posedge sclk) disable iff (!frame_rst_n)
		(state_r == ST_RD && !word_end && !resync)
		|=> serial_out == $past(tx_r[22]))
		else $error("read data not shifted msb first");
	gain_write_a: assert property (
		@(posedge sclk) disable iff (!frame_rst_n)
		(wr_commit && tgt_r == TGT_GAIN)
		|=> gain1_r == $past(rx_next) && state_r == ST_CMD)
		else $error("gain write not stored");
	job_time_a: assert property (
		@(posedge clock) disable iff (!rstn)
		start_evt |=> busy_r && cnt_r == (cal_r ? CAL_LOAD : CONV_LOAD))
		else $error("job length not loaded");
	done_flag_a: assert property (
		@(posedge clock) disable iff (!rstn)
		(busy_r && cnt_r == 16'h0000) |=> !busy_r && done_tgl_r == seen_r)
		else $error("completion not signalled");
	cal_target_a: assert property (
		@(posedge clock) disable iff (!rstn)
		(busy_r && cal_r && cnt_r == 16'h0000)
		|=> ofs_mem[$past(chan_r)] == $past(analog_sample))
		else $error("calibration stored in wrong channel");

endmodule : adc_serial_command_port

/* File: testbench/host_model.sv */
// Host model that bit-bangs the converter's serial command port.
// Assumes the bench calls its tasks one at a time, never in parallel.
module host_model (
	output logic      sclk,
	output logic      cs_n,
	output logic      serial_in,
	input  wire logic serial_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle levels: clock low and still between frames, chip deselected.
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		serial_in = 1'b1;
	end

	// Shift n bits MSB first; data changes while sclk is low.
	task automatic shift(input logic [23:0] tx, input int n,
		output logic [23:0] rx);
		rx = 24'h000000;
		for (int i = n - 1; i >= 0; i--) begin
			serial_in = tx[i];
			#7.5;
			rx = {rx[22:0], serial_out};
			sclk = 1'b1;
			#7.5;
			sclk = 1'b0;
		end
		serial_in = ~serial_in; // A released line never shows the last bit.
	endtask : shift

	// Chip select frames every command.
	task automatic open_frame();
		cs_n = 1'b0;
		#10;
	endtask : open_frame

	task automatic close_frame();
		#10;
		cs_n = 1'b1;
		#10;
	endtask : close_frame

	// One command byte and exactly three data bytes.
	task automatic write_reg(input logic [7:0] cmd, input logic [23:0] d);
		logic [23:0] junk;
		open_frame();
		shift({16'h0000, cmd}, 8, junk);
		shift(d, 24, junk);
		close_frame();
	endtask : write_reg

	task automatic read_reg(input logic [7:0] cmd, output logic [23:0] d);
		logic [23:0] junk;
		open_frame();
		shift({16'h0000, cmd}, 8, junk);
		shift(24'h000000, 24, d);
		close_frame();
	endtask : read_reg
endmodule : host_model

/* File: testbench/tb_adc_serial_command_port.sv */
// Self-checking bench for the serial command port.
// Assumes the host model owns the link pins and makes the bit clock.
module tb_adc_serial_command_port;
	timeunit 1ns;
	timeprecision 100ps;
	import adc_port_pkg::*;

	logic        clock, rstn, sclk, cs_n, serial_in, serial_out, busy;
	logic        mc, lp, rc, pol;
	logic [3:0]  depth;
	logic [2:0]  chan, rng, output_word_rate;
	logic [1:0]  latch;
	logic [23:0] sample, gain, rx;
	int          num_errors, total_checks;

	adc_serial_command_port #(.CONV_CYCLES(8), .CAL_CYCLES(8)) dut (
		.clock(clock), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
		.serial_in(serial_in), .analog_sample(sample),
		.serial_out(serial_out), .depth_pointer(depth),
		.multi_conversion_bit(mc), .loop_bit(lp), .read_convert_bit(rc),
		.gain_channel_one(gain), .conv_busy(busy), .active_channel(chan),
		.active_polarity(pol), .active_range(rng), .active_owr(output_word_rate),
		.latch_outputs(latch));
	host_model host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
		.serial_out(serial_out));

	// Clock and time-zero values; reset is released by the main sequence.
	initial begin
		clock = 1'b0;
		rstn = 1'b0;
		sample = 24'h000000;
		num_errors = 0;
		total_checks = 0;
	end
	always #10 clock = ~clock;

	task automatic check(input string what, input logic [23:0] seen,
		input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic close_out();
		if (num_errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out

	// Polls the done level with a bound, and notes whether the engine ran.
	task automatic wait_done(output logic ran);
		int n;
		ran = 1'b0;
		n = 0;
		while (serial_out !== 1'b0 && n < 200) begin
			@(posedge clock);
			ran |= busy;
			n++;
		end
		check("done", {23'h0, n < 200}, 24'h000001);
	endtask : wait_done

	task automatic t_reset();
		check("depth", {20'h0, depth}, 24'h000000);
		check("flags", {19'h0, mc, lp, rc, busy, serial_out}, 24'h0);
		check("gain", gain, GAIN_RESET);
		host.read_reg(CMD_CFG_RD, rx);
		check("cfg", rx, CFG_RESET);
	endtask : t_reset

	task automatic t_config();
		host.write_reg(CMD_CFG_WR, 24'h0B3C5A);
		check("depth", {20'h0, depth}, 24'h000003);
		check("mc lp rc", {21'h0, mc, lp, rc}, 24'h000005);
		host.read_reg(CMD_CFG_RD, rx);
		check("cfg rd", rx, 24'h0B3C5A);
	endtask : t_config

	// The first two setup registers go in one burst, then read back in the frame.
	task automatic t_csr();
		logic [23:0] a, b;
		host.read_reg(CMD_CFG_RD, rx);
		host.write_reg(CMD_CFG_WR, (rx & 24'hF10FFF) | 24'h003000);
		host.open_frame();
		host.shift({16'h0, CMD_CSR_WR}, 8, rx);
		host.shift(24'h4C0105, 24, rx);
		host.shift(24'h123456, 24, rx);
		host.shift({16'h0, CMD_CSR_RD}, 8, rx);
		host.shift(24'h000000, 24, a);
		host.shift(24'h000000, 24, b);
		host.close_frame();
		check("csr0", a, 24'h4C0105);
		check("csr1", b, 24'h123456);
		host.read_reg(CMD_CFG_RD, rx);
		check("cfg rmw", rx, 24'h013C5A);
	endtask : t_csr

	task automatic t_gain();
		host.open_frame();
		host.shift({16'h0, CMD_GAIN_WR}, 8, rx);
		host.shift(24'h800000, 24, rx);
		host.shift({16'h0, CMD_GAIN_RD}, 8, rx);
		host.shift(24'h000000, 24, rx);
		host.close_frame();
		check("gain rd", rx, 24'h800000);
		check("gain", gain, 24'h800000);
	endtask : t_gain

	// An unknown byte is dropped; bits without chip select are ignored.
	task automatic t_ignore();
		host.open_frame();
		host.shift(24'h000055, 8, rx);
		host.shift({16'h0, CMD_CFG_RD}, 8, rx);
		host.shift(24'h000000, 24, rx);
		host.close_frame();
		check("unknown", rx, 24'h013C5A);
		host.shift({16'h0, CMD_CFG_WR}, 8, rx);
		host.shift(24'hFFFFFF, 24, rx);
		check("no select", {20'h0, depth}, 24'h000003);
	endtask : t_ignore

	// Three stray bits misalign the port; only the resync realigns it.
	task automatic t_resync();
		host.open_frame();
		host.shift(24'h000000, 3, rx);
		repeat (15) host.shift(24'h0000FF, 8, rx);
		host.shift(24'h0000FE, 8, rx);
		host.shift({16'h0, CMD_CFG_RD}, 8, rx);
		host.shift(24'h000000, 24, rx);
		host.close_frame();
		check("resync", rx, 24'h013C5A);
	endtask : t_resync

	task automatic t_cal();
		logic ran;
		@(posedge clock);
		sample <= 24'h000100;
		host.open_frame();
		host.shift({16'h0, CMD_SELF_OFS}, 8, rx);
		check("pending", {23'h0, serial_out}, 24'h000001);
		wait_done(ran);
		host.close_frame();
		check("cal ran", {23'h0, ran}, 24'h000001);
		check("setup1", {12'h0, latch, chan, output_word_rate, rng, pol}, 24'h4C0);
	endtask : t_cal

	// Result is the sample less the offset stored for setup one's channel.
	task automatic t_conv();
		logic ran;
		@(posedge clock);
		sample <= 24'h123456;
		host.open_frame();
		host.shift({16'h0, CMD_CONVERT}, 8, rx);
		check("pending", {23'h0, serial_out}, 24'h000001);
		wait_done(ran);
		host.shift(24'h000000, 8, rx);
		host.shift(24'h000000, 24, rx);
		host.close_frame();
		check("result", rx, 24'h123356);
		check("conv ran", {23'h0, ran}, 24'h000001);
	endtask : t_conv

	task automatic t_refuse();
		logic ran;
		host.write_reg(CMD_CFG_WR, 24'h053C5A);
		host.open_frame();
		host.shift({16'h0, CMD_CONVERT}, 8, rx);
		ran = 1'b0;
		repeat (20) begin
			@(posedge clock);
			ran |= busy;
		end
		host.close_frame();
		check("loop refuse", {23'h0, ran}, 24'h000000);
	endtask : t_refuse

	// Main sequence: 12 reset cycles, then every scenario in turn.
	initial begin
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		t_reset();
		t_config();
		t_csr();
		t_gain();
		t_ignore();
		t_resync();
		t_cal();
		t_conv();
		t_refuse();
		close_out();
	end

	// The run needs about 600 clock cycles; this cuts a hang short.
	initial begin
		#100000;
		num_errors++;
		close_out();
	end
endmodule : tb_adc_serial_command_port
